// ===== rtl/cra_regs.vh
// Purpose: constants for the configuration request interpreter
// Assumes: token stream of 8-bit symbols, each tagged data or control
// Notes: destination low halves accept tile or node; both reach the one bank
`ifndef CRA_REGS_VH
`define CRA_REGS_VH
`define CRA_TOK_WRITE 8'hC0
`define CRA_TOK_READ 8'hC1
`define CRA_TOK_END 8'h01
`define CRA_TOK_ACK 8'h03
`define CRA_TOK_NACK 8'h04
`define CRA_DEST_TILE 16'hC20C
`define CRA_DEST_NODE 16'hC30C
`define CRA_NOREPLY_MASK 8'hFF
`define CRA_PS_RES_TYPE 8'h0C
`define CRA_HDR_BYTES 3'h5
`define CRA_WR_BYTES 4'h9
`define CRA_DATA_BYTES 3'h4
`define CRA_ADDR_BYTES 4'h3
`define CRA_SHORT_REPLY 3'h2
`define CRA_LONG_REPLY 3'h6
`endif

// ===== rtl/cra_skid.v
// Purpose: two-entry buffer between reply generator and output link
// Assumes: valid/ready handshake on both sides
// Notes: ready drops only when both entries hold words
`timescale 1ns/10ps
module cra_skid #(
  parameter WIDTH = 9
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output reg out_valid_out,
  input wire out_ready_in,
  output reg [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] spare;
  reg spare_valid;
  assign in_ready_out = ~spare_valid;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      out_valid_out <= 1'b0;
      spare_valid <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
      spare <= {WIDTH{1'b0}};
    end else begin
      if (!out_valid_out || out_ready_in) begin
        if (spare_valid) begin
          out_data_out <= spare;
          out_valid_out <= 1'b1;
          spare_valid <= 1'b0;
        end else begin
          out_data_out <= in_data_in;
          out_valid_out <= in_valid_in;
        end
      end else if (in_valid_in && !spare_valid) begin
        // output stalled: park word rather than drop it
        spare <= in_data_in;
        spare_valid <= 1'b1;
      end
    end
  end
endmodule

// ===== rtl/cra_bank.v
// Purpose: configuration register storage for one tile or node bank
// Assumes: single-cycle access, one access per strobe
// Notes: numbers at or above DEPTH fail, as do writes to read-only slot 0
`timescale 1ns/10ps
module cra_bank #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire strobe_in,
  input wire write_in,
  input wire [15:0] num_in,
  input wire [31:0] wdata_in,
  output reg ok_out,
  output reg [31:0] rdata_out
);
  reg [31:0] mem [0:DEPTH-1];
  wire hit = (num_in < DEPTH);
  wire [AW-1:0] idx = num_in[AW-1:0];
  integer i;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      ok_out <= 1'b0;
      rdata_out <= 32'h00000000;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 32'h00000000;
    end else if (strobe_in) begin
      // slot 0 is read-only so failure replies are reachable
      ok_out <= hit && !(write_in && idx == {AW{1'b0}});
      rdata_out <= hit ? mem[idx] : 32'h00000000;
      if (write_in && hit && idx != {AW{1'b0}})
        mem[idx] <= wdata_in;
    end
  end
endmodule

// ===== rtl/cra_top.v
// Purpose: interpreter for configuration read/write token messages
// Assumes: input stream is 8-bit symbols with a control flag, sync to clk_in
// Notes: replies leave through a two-entry buffer; reply address is an output
`timescale 1ns/10ps
`include "cra_regs.vh"
module cra_top #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire [31:0] dest_in,
  input wire rx_valid_in,
  input wire rx_ctrl_in,
  input wire [7:0] rx_data_in,
  output reg rx_ready_out,
  output wire tx_valid_out,
  output wire tx_ctrl_out,
  output wire [7:0] tx_data_out,
  input wire tx_ready_in,
  output reg [23:0] reply_addr_out,
  output reg [15:0] ps_res_id_out
);
  localparam S_IDLE = 7'h01;
  localparam S_HDR = 7'h02;
  localparam S_DATA = 7'h04;
  localparam S_END = 7'h08;
  localparam S_ACC = 7'h10;
  localparam S_WAIT = 7'h20;
  localparam S_REPLY = 7'h40;

  reg [6:0] state;
  reg is_write;
  reg bad;
  reg [3:0] cnt;
  reg [23:0] raddr;
  reg [15:0] num;
  reg [31:0] wdata;
  reg [2:0] rcnt;
  reg acc_strobe;
  wire bank_ok;
  wire [31:0] bank_rdata;
  reg buf_valid;
  reg [8:0] buf_word;
  wire buf_ready;
  wire [8:0] tx_word;
  // next values, decoded in one process below
  reg [6:0] next_state;
  reg next_is_write;
  reg next_bad;
  reg [3:0] next_cnt;
  reg [23:0] next_raddr;
  reg [15:0] next_num;
  reg [31:0] next_wdata;
  reg [2:0] next_rcnt;
  reg next_acc_strobe;
  reg next_rx_ready;
  reg [23:0] next_reply_addr;
  reg [15:0] next_ps_res_id;

  // shift one byte in at the low end, so first byte lands on top
  function [31:0] shift_in;
    input [31:0] cur;
    input [7:0] b;
    begin
      shift_in = {cur[23:0], b};
    end
  endfunction

  // last index of a reply of len symbols
  function is_last;
    input [2:0] idx;
    input [2:0] len;
    begin
      is_last = (idx == len - 3'h1);
    end
  endfunction

  // byte k of a word counted from the top, so the msb leaves first
  function [7:0] top_byte;
    input [31:0] word;
    input [2:0] k;
    begin
      case (k)
        3'h1: top_byte = word[31:24];
        3'h2: top_byte = word[23:16];
        3'h3: top_byte = word[15:8];
        default: top_byte = word[7:0];
      endcase
    end
  endfunction

  // status resource id: register number moved up a byte, type code below
  function [15:0] ps_id;
    input [15:0] reg_num;
    begin
      ps_id = {reg_num[7:0], `CRA_PS_RES_TYPE};
    end
  endfunction

  wire take = rx_valid_in && rx_ready_out;
  wire dest_ok = (dest_in[15:0] == `CRA_DEST_TILE) ||
    (dest_in[15:0] == `CRA_DEST_NODE);
  wire [2:0] reply_len = (is_write || !bank_ok || bad) ? `CRA_SHORT_REPLY : `CRA_LONG_REPLY;
  wire reply_last = is_last(rcnt, reply_len);
  wire is_opening = rx_ctrl_in &&
    (rx_data_in == `CRA_TOK_WRITE || rx_data_in == `CRA_TOK_READ);
  wire is_closing = rx_ctrl_in && (rx_data_in == `CRA_TOK_END);
  // a token inside a field cuts the message; no retry, the reply says failure
  wire cut_short = take && rx_ctrl_in;
  wire no_reply = is_write && !bad && (raddr[7:0] == `CRA_NOREPLY_MASK);
  // one shift function serves all three fields; only the live bytes are kept
  wire [31:0] raddr_shifted = shift_in({8'h00, raddr}, rx_data_in);
  wire [31:0] num_shifted = shift_in({16'h0000, num}, rx_data_in);
  wire [31:0] wdata_shifted = shift_in(wdata, rx_data_in);

  cra_bank #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_bank (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .strobe_in(acc_strobe),
    .write_in(is_write),
    .num_in(num),
    .wdata_in(wdata),
    .ok_out(bank_ok),
    .rdata_out(bank_rdata)
  );

  cra_skid #(
    .WIDTH(9)
  ) u_buf (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(buf_valid),
    .in_ready_out(buf_ready),
    .in_data_in(buf_word),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_word)
  );
  assign tx_ctrl_out = tx_word[8];
  assign tx_data_out = tx_word[7:0];

  // reply word for index rcnt: ctrl flag in bit 8
  always @* begin
    buf_valid = (state == S_REPLY);
    if (bad || !bank_ok) begin
      buf_word = (rcnt == 3'h0) ? {1'b1, `CRA_TOK_NACK} : {1'b1, `CRA_TOK_END};
    end else if (rcnt == 3'h0) begin
      buf_word = {1'b1, `CRA_TOK_ACK};
    end else if (reply_last) begin
      buf_word = {1'b1, `CRA_TOK_END};
    end else begin
      buf_word = {1'b0, top_byte(bank_rdata, rcnt)};
    end
  end

  // next-state and capture decode; the registers below only take these values
  always @* begin
    next_state = state;
    next_is_write = is_write;
    next_bad = bad;
    next_cnt = cnt;
    next_raddr = raddr;
    next_num = num;
    next_wdata = wdata;
    next_rcnt = rcnt;
    next_acc_strobe = 1'b0;
    next_rx_ready = rx_ready_out;
    next_reply_addr = reply_addr_out;
    next_ps_res_id = ps_res_id_out;
    case (state)
      S_IDLE: begin
        next_rx_ready = 1'b1;
        if (take) begin
          next_cnt = 4'h0;
          next_bad = 1'b0;
          // unknown opening tokens and foreign destinations are dropped silently
          if (is_opening && dest_ok) begin
            next_is_write = (rx_data_in == `CRA_TOK_WRITE);
            next_state = S_HDR;
          end
        end
      end
      S_HDR: begin
        // 3 address bytes then 2 number bytes, msb first
        if (cut_short) begin
          next_bad = 1'b1;
          next_rx_ready = 1'b0;
          next_state = S_ACC;
        end else if (take) begin
          if (cnt < `CRA_ADDR_BYTES)
            next_raddr = raddr_shifted[23:0];
          else
            next_num = num_shifted[15:0];
          next_cnt = cnt + 4'h1;
          if (cnt == {1'b0, `CRA_HDR_BYTES} - 4'h1)
            next_state = is_write ? S_DATA : S_END;
        end
      end
      S_DATA: begin
        if (cut_short) begin
          next_bad = 1'b1;
          next_rx_ready = 1'b0;
          next_state = S_ACC;
        end else if (take) begin
          next_wdata = wdata_shifted;
          next_cnt = cnt + 4'h1;
          if (cnt == `CRA_WR_BYTES - 4'h1)
            next_state = S_END;
        end
      end
      S_END: begin
        if (take) begin
          // long or malformed message answers failure without access
          if (!is_closing)
            next_bad = 1'b1;
          next_rx_ready = 1'b0;
          next_state = S_ACC;
        end
      end
      S_ACC: begin
        next_acc_strobe = !bad;
        next_reply_addr = raddr;
        next_ps_res_id = ps_id(num);
        next_state = S_WAIT;
      end
      S_WAIT: begin
        next_rcnt = 3'h0;
        if (no_reply)
          next_state = S_IDLE;
        else
          next_state = S_REPLY;
      end
      S_REPLY: begin
        if (buf_ready) begin
          next_rcnt = rcnt + 3'h1;
          if (reply_last)
            next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // control registers
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= S_IDLE;
      is_write <= 1'b0;
      bad <= 1'b0;
      cnt <= 4'h0;
      rcnt <= 3'h0;
      acc_strobe <= 1'b0;
    end else begin
      state <= next_state;
      is_write <= next_is_write;
      bad <= next_bad;
      cnt <= next_cnt;
      rcnt <= next_rcnt;
      acc_strobe <= next_acc_strobe;
    end
  end

  // captured message fields
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      raddr <= 24'h000000;
      num <= 16'h0000;
      wdata <= 32'h00000000;
    end else begin
      raddr <= next_raddr;
      num <= next_num;
      wdata <= next_wdata;
    end
  end

  // ready resets high so a request may start on the first edge after reset
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      rx_ready_out <= 1'b1;
      reply_addr_out <= 24'h000000;
      ps_res_id_out <= 16'h0000;
    end else begin
      rx_ready_out <= next_rx_ready;
      reply_addr_out <= next_reply_addr;
      ps_res_id_out <= next_ps_res_id;
    end
  end
endmodule

// ===== testbench/cra_top_monitor.sv
// Purpose: port checker for cra_top
// Assumes: one clock, sync low reset
// Notes: reply lengths judged by the bench
`timescale 1ns/10ps
`include "cra_regs.vh"
module cra_top_monitor (
  input wire clk_in,
  input wire reset_n_in,
  input wire [31:0] dest_in,
  input wire rx_valid_in,
  input wire rx_ctrl_in,
  input wire [7:0] rx_data_in,
  input wire rx_ready_out,
  input wire tx_valid_out,
  input wire tx_ctrl_out,
  input wire [7:0] tx_data_out,
  input wire tx_ready_in,
  input wire [15:0] ps_res_id_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire tk = rx_valid_in && rx_ready_out;
  wire ok = dest_in[15:0] == `CRA_DEST_TILE || dest_in[15:0] == `CRA_DEST_NODE;
  wire tx_tk = tx_valid_out && tx_ready_in;
  a_tx_valid_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out)
    else $error("reply withdrawn");
  a_tx_data_hold: assert property (tx_valid_out && !tx_ready_in |=>
    $stable({tx_ctrl_out, tx_data_out})) else $error("reply changed");
  a_end_busy: assert property (tk && rx_ctrl_in && rx_data_in == `CRA_TOK_END && ok
    |=> !rx_ready_out [*2]) else $error("ready after end");
  a_ready_back: assert property (!rx_ready_out |-> ##[1:60] rx_ready_out)
    else $error("stuck busy");
  a_tok_legal: assert property (tx_valid_out && tx_ctrl_out |-> tx_data_out ==
    `CRA_TOK_ACK || tx_data_out == `CRA_TOK_NACK || tx_data_out == `CRA_TOK_END)
    else $error("bad token");
  a_ps_low: assert property ($changed(ps_res_id_out) |->
    ps_res_id_out[7:0] == `CRA_PS_RES_TYPE) else $error("ps id type");
  a_drop_wrong: assert property (tk && rx_ctrl_in && !ok |=> rx_ready_out)
    else $error("foreign taken");
  a_idle_ready: assert property ($rose(reset_n_in) |-> rx_ready_out)
    else $error("not ready");
  cover property (tk && rx_ctrl_in && rx_data_in == `CRA_TOK_WRITE);
  cover property (tx_tk && tx_ctrl_out && tx_data_out == `CRA_TOK_NACK);
  cover property (tx_valid_out && !tx_ready_in);
endmodule
bind cra_top cra_top_monitor mon_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .dest_in(dest_in), .rx_valid_in(rx_valid_in), .rx_ctrl_in(rx_ctrl_in),
  .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
  .tx_ctrl_out(tx_ctrl_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
  .ps_res_id_out(ps_res_id_out));

// ===== testbench/cra_req.sv
// Purpose: requesting channel-end model
// Assumes: symbols are {ctrl, byte}
// Notes: slow mode toggles ready to stall replies
`timescale 1ns/10ps
`include "cra_regs.vh"
module cra_req (
  input wire clk_in,
  input wire rx_ready_in,
  input wire tx_valid_in,
  input wire tx_ctrl_in,
  input wire [7:0] tx_data_in,
  output logic valid_out,
  output logic ctrl_out,
  output logic [7:0] data_out,
  output logic ready_out
);
  logic slow = 1'b0;
  logic [8:0] got[$];
  initial begin
    valid_out = 1'b0;
    {ctrl_out, data_out} = 9'h1FF;
    ready_out = 1'b1;
  end
  always @(posedge clk_in) begin
    if (tx_valid_in && ready_out) got.push_back({tx_ctrl_in, tx_data_in});
    ready_out <= slow ? ~ready_out : 1'b1;
  end
  // held until taken; valid stays up between symbols
  task send(input logic [8:0] s);
    valid_out <= 1'b1;
    {ctrl_out, data_out} <= s;
    @(posedge clk_in);
    while (!rx_ready_in) @(posedge clk_in);
  endtask
  // bad ends the message inside the number field
  task req(input logic wr, input logic [23:0] ra, input logic [15:0] n,
    input logic [31:0] d, input logic bad);
    send({1'b1, wr ? `CRA_TOK_WRITE : `CRA_TOK_READ});
    for (int i = 2; i >= 0; i--) send({1'b0, ra[i*8 +: 8]});
    send({1'b0, n[15:8]});
    if (!bad) begin
      send({1'b0, n[7:0]});
      if (wr) for (int i = 3; i >= 0; i--) send({1'b0, d[i*8 +: 8]});
    end
    send({1'b1, `CRA_TOK_END});
    valid_out <= 1'b0;
    {ctrl_out, data_out} <= 9'h0FE; // released line shows the inverse
  endtask
endmodule

// ===== testbench/config_register_access_protocol_tb.sv
// Purpose: self-checking bench for cra_top
// Assumes: bank of 16 words, word 0 read-only
// Notes: replies collected by the partner model
`timescale 1ns/10ps
`include "cra_regs.vh"
module config_register_access_protocol_tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [31:0] dest = 32'h0001C20C;
  logic rv, rc, rr, tv, tc, tr;
  logic [7:0] rd, td;
  logic [23:0] ra;
  logic [15:0] ps;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #50 clk_in = ~clk_in;
  cra_top dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .dest_in(dest),
    .rx_valid_in(rv), .rx_ctrl_in(rc), .rx_data_in(rd), .rx_ready_out(rr),
    .tx_valid_out(tv), .tx_ctrl_out(tc), .tx_data_out(td), .tx_ready_in(tr),
    .reply_addr_out(ra), .ps_res_id_out(ps));
  cra_req p_u (.clk_in(clk_in), .rx_ready_in(rr), .tx_valid_in(tv), .tx_ctrl_in(tc),
    .tx_data_in(td), .valid_out(rv), .ctrl_out(rc), .data_out(rd), .ready_out(tr));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %0h expected %0h", $time, g, e);
    end
  endtask
  // e holds n symbols, first one highest
  task reply(input logic [53:0] e, input int n);
    for (int t = 0; t < 200 && p_u.got.size() < n; t++) @(posedge clk_in);
    repeat (10) @(posedge clk_in);
    chk(p_u.got.size(), n);
    for (int k = 0; k < n && k < p_u.got.size(); k++) chk(p_u.got[k], e[(n-1-k)*9 +: 9]);
    p_u.got.delete();
  endtask
  task t_write;
    p_u.req(1'b1, 24'h123405, 16'h0005, 32'hA5A51234, 1'b0);
    reply({9'h103, 9'h101}, 2);
    chk(ra, 24'h123405);
    chk(ps, 16'h050C);
  endtask
  task t_read_node;
    dest <= 32'h0002C30C;
    p_u.req(1'b0, 24'h123406, 16'h0005, 32'h0, 1'b0);
    reply({9'h103, 9'h0A5, 9'h0A5, 9'h012, 9'h034, 9'h101}, 6);
  endtask
  task t_fail;
    p_u.req(1'b1, 24'h123407, 16'h0000, 32'h1, 1'b0);
    reply({9'h104, 9'h101}, 2);
    p_u.req(1'b0, 24'h123407, 16'h0010, 32'h0, 1'b0);
    reply({9'h104, 9'h101}, 2);
    p_u.req(1'b0, 24'h123407, 16'h0005, 32'h0, 1'b1);
    reply({9'h104, 9'h101}, 2);
  endtask
  // silent write, then read back with the receiver stalling
  task t_silent;
    p_u.req(1'b1, 24'h1234FF, 16'h000F, 32'hCAFE0001, 1'b0);
    reply(54'h0, 0);
    p_u.slow = 1'b1;
    p_u.req(1'b0, 24'h123408, 16'h000F, 32'h0, 1'b0);
    reply({9'h103, 9'h0CA, 9'h0FE, 9'h000, 9'h001, 9'h101}, 6);
    p_u.slow = 1'b0;
  endtask
  task t_bad_dest;
    dest <= 32'h0001C00C;
    p_u.req(1'b0, 24'h123409, 16'h0005, 32'h0, 1'b0);
    reply(54'h0, 0);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_write;
    t_read_node;
    t_fail;
    t_silent;
    t_bad_dest;
    report_and_stop;
  end
endmodule
